// ### rtl/uds_top.sv
`timescale 1ns/1ps
`include "uds_defs.svh"

module uds_top
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_sel,
  input  wire logic [3:0]  wr_be,
  input  wire logic [31:0] wr_data,
  input  wire logic        irq_en,
  output logic      [31:0] quotient,
  output logic      [31:0] remainder,
  output logic      [15:0] root,
  output logic             busy,
  output logic             done_flag,
  output logic             zero_div_flag,
  output logic             irq
);

  uds_pkg::uds_state_t state;
  uds_pkg::uds_state_t next_state;
  logic [2:0]          cnt;
  logic [2:0]          next_cnt;
  logic [31:0]         dividend;
  logic [31:0]         next_dividend;
  logic [31:0]         divisor;
  logic [31:0]         next_divisor;
  logic [31:0]         radicand;
  logic [31:0]         next_radicand;
  logic                next_busy;
  logic                next_done;
  logic                next_zero;
  logic                next_irq;
  logic                last_root;
  logic                next_last_root;
  logic                take;
  logic                start_div;
  logic                start_root;
  logic                stepping;
  logic                last_step;

  // a write is taken only as a whole word and only while idle;
  // refusing busy writes keeps the running operands stable
  assign take       = wr_en && (wr_be == `UDS_BE_WORD) && (state == uds_pkg::UDS_IDLE);
  assign start_div  = take && (wr_sel == `UDS_SEL_DIVISOR);
  assign start_root = take && (wr_sel == `UDS_SEL_RADICAND);
  assign stepping   = (state != uds_pkg::UDS_IDLE);
  assign last_step  = stepping && (cnt == `UDS_STEP_LAST);

  // operand holding registers
  always_comb
  begin
    next_dividend = dividend;
    next_divisor  = divisor;
    next_radicand = radicand;
    if (take && (wr_sel == `UDS_SEL_DIVIDEND))
    begin
      next_dividend = wr_data;
    end
    if (start_div)
    begin
      next_divisor = wr_data;
    end
    if (start_root)
    begin
      next_radicand = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dividend <= `UDS_ZERO32;
      divisor  <= `UDS_ZERO32;
      radicand <= `UDS_ZERO32;
    end
    else
    begin
      dividend <= next_dividend;
      divisor  <= next_divisor;
      radicand <= next_radicand;
    end
  end

  // sequencer: eight stepping cycles, then back to idle with done set
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_last_root = last_root;
    case (state)
      uds_pkg::UDS_IDLE:
      begin
        next_cnt = `UDS_STEP_ZERO;
        if (start_div)
        begin
          next_state     = uds_pkg::UDS_DIV;
          next_last_root = 1'b0;
        end
        else if (start_root)
        begin
          next_state     = uds_pkg::UDS_ROOT;
          next_last_root = 1'b1;
        end
      end
      uds_pkg::UDS_DIV, uds_pkg::UDS_ROOT:
      begin
        next_cnt = cnt + `UDS_STEP_ONE;
        if (cnt == `UDS_STEP_LAST)
        begin
          next_state = uds_pkg::UDS_IDLE;
          next_cnt   = `UDS_STEP_ZERO;
        end
      end
      default:
      begin
        next_state = uds_pkg::UDS_IDLE;
        next_cnt   = `UDS_STEP_ZERO;
      end
    endcase
  end

  // status flags; a start clears done, the final step sets it
  always_comb
  begin
    next_busy = (next_state != uds_pkg::UDS_IDLE);
    next_done = done_flag;
    next_zero = zero_div_flag;
    if (start_div || start_root)
    begin
      next_done = 1'b0;
    end
    if (last_step)
    begin
      next_done = 1'b1;
    end
    if (start_div)
    begin
      next_zero = (wr_data == `UDS_ZERO32);
    end
    // interrupt follows the polled flag while software enables it
    next_irq = irq_en && done_flag;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state         <= uds_pkg::UDS_IDLE;
      cnt           <= `UDS_STEP_ZERO;
      last_root     <= 1'b0;
      busy          <= 1'b0;
      done_flag     <= 1'b0;
      zero_div_flag <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      cnt           <= next_cnt;
      last_root     <= next_last_root;
      busy          <= next_busy;
      done_flag     <= next_done;
      zero_div_flag <= next_zero;
      irq           <= next_irq;
    end
  end

  // iterative datapath; results sit in its own registers
  uds_engine u_engine
  (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .load      (start_div || start_root),
    .step      (stepping),
    .mode_root (start_root),
    .opa       (start_root ? wr_data : dividend),
    .opb       (wr_data),
    .quotient  (quotient),
    .remainder (remainder),
    .root      (root)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_word_only_take:
    assert property (!busy && wr_en && (wr_be != `UDS_BE_WORD) |=> !busy && $stable(dividend))
    else $error("partial write was taken");

  a_div_eight_cycles:
    assert property (start_div |=> !done_flag [*8] ##1 done_flag)
    else $error("division did not end in eight cycles");

  a_div_result_ok:
    assert property ($rose(done_flag) && !last_root && (divisor != `UDS_ZERO32)
      |-> ({32'h0, quotient} * {32'h0, divisor} + {32'h0, remainder} == {32'h0, dividend})
          && (remainder < divisor))
    else $error("division result wrong");

  a_zero_div_flag:
    assert property (start_div && (wr_data == `UDS_ZERO32) |=> zero_div_flag [*8])
    else $error("zero divisor flag missing");

  a_root_eight_cycles:
    assert property (start_root |=> busy [*8] ##1 (done_flag && !busy))
    else $error("root did not end in eight cycles");

  a_root_floor_ok:
    assert property ($rose(done_flag) && last_root
      |-> ({16'h0, root} * {16'h0, root} <= radicand)
          && (({17'h0, root} + 33'h1) * ({17'h0, root} + 33'h1) > {1'b0, radicand}))
    else $error("root is not the floor");

  a_unsigned_top_bit:
    assert property ($rose(done_flag) && !last_root && divisor[31] && !dividend[31]
      |-> (quotient == `UDS_ZERO32) && (remainder == dividend))
    else $error("operands not treated as unsigned");

  a_irq_tracks_done:
    assert property (irq_en && done_flag |=> irq)
    else $error("enabled interrupt not raised");

  a_zero_div_result:
    assert property ($rose(done_flag) && !last_root && (divisor == `UDS_ZERO32)
      |-> (quotient == `UDS_ONES32) && (remainder == dividend) && zero_div_flag)
    else $error("zero divisor result wrong");

  a_start_clears_done:
    assert property (start_div || start_root |=> !done_flag && busy)
    else $error("done not cleared at start");

endmodule

// ### rtl/uds_defs.svh
`ifndef UDS_DEFS_SVH
`define UDS_DEFS_SVH

// operand select codes on the write port
`define UDS_SEL_DIVIDEND  2'h0
`define UDS_SEL_DIVISOR   2'h1
`define UDS_SEL_RADICAND  2'h2

// byte enables of a full word access
`define UDS_BE_WORD       4'hF

// eight stepping cycles per operation, counted 0..7
`define UDS_STEP_LAST     3'h7
`define UDS_STEP_ONE      3'h1
`define UDS_STEP_ZERO     3'h0

// quotient bits and root bits resolved per cycle
`define UDS_DIV_BITS      4
`define UDS_ROOT_BITS     2

// reset and special values
`define UDS_ZERO32        32'h0000_0000
`define UDS_ONES32        32'hFFFF_FFFF
`define UDS_ZERO33        33'h0_0000_0000
`define UDS_ZERO16        16'h0000

`endif

// ### rtl/uds_pkg.sv
package uds_pkg;

  // operation sequencer states
  typedef enum logic [1:0]
  {
    UDS_IDLE = 2'b00,
    UDS_DIV  = 2'b01,
    UDS_ROOT = 2'b10
  } uds_state_t;

endpackage

// ### rtl/uds_engine.sv
`timescale 1ns/1ps
`include "uds_defs.svh"

module uds_engine
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        load,
  input  wire logic        step,
  input  wire logic        mode_root,
  input  wire logic [31:0] opa,
  input  wire logic [31:0] opb,
  output logic      [31:0] quotient,
  output logic      [31:0] remainder,
  output logic      [15:0] root
);

  logic [32:0] acc;
  logic [31:0] shf;
  logic [31:0] den;
  logic [15:0] rt;
  logic        root_op;
  logic [32:0] next_acc;
  logic [31:0] next_shf;
  logic [31:0] next_den;
  logic [15:0] next_rt;
  logic        next_root_op;

  // one cycle of restoring division (four bits) or digit-pair root (two bits);
  // all arithmetic is unsigned, the operands carry no sign
  always_comb
  begin
    logic [32:0] tmp;
    logic [18:0] rtmp;
    logic [18:0] trial;
    tmp          = `UDS_ZERO33;
    rtmp         = 19'h0_0000;
    trial        = 19'h0_0000;
    next_acc     = acc;
    next_shf     = shf;
    next_den     = den;
    next_rt      = rt;
    next_root_op = root_op;
    if (load)
    begin
      next_acc     = `UDS_ZERO33;
      next_shf     = opa;
      next_den     = opb;
      next_rt      = `UDS_ZERO16;
      next_root_op = mode_root;
    end
    else if (step && !root_op)
    begin
      // a zero divisor makes every trial succeed: all-ones quotient, dividend left over
      for (int k = 0; k < `UDS_DIV_BITS; k++)
      begin
        tmp      = {next_acc[31:0], next_shf[31]};
        next_shf = {next_shf[30:0], 1'b0};
        if (tmp >= {1'b0, next_den})
        begin
          next_acc    = tmp - {1'b0, next_den};
          next_shf[0] = 1'b1;
        end
        else
        begin
          next_acc = tmp;
        end
      end
    end
    else if (step)
    begin
      // remainder never exceeds twice the partial root, so 19 bits suffice
      for (int k = 0; k < `UDS_ROOT_BITS; k++)
      begin
        rtmp     = {next_acc[16:0], next_shf[31:30]};
        next_shf = {next_shf[29:0], 2'b00};
        trial    = {1'b0, next_rt, 2'b01};
        if (rtmp >= trial)
        begin
          next_acc = {14'h0000, rtmp - trial};
          next_rt  = {next_rt[14:0], 1'b1};
        end
        else
        begin
          next_acc = {14'h0000, rtmp};
          next_rt  = {next_rt[14:0], 1'b0};
        end
      end
    end
  end

  // datapath registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc     <= `UDS_ZERO33;
      shf     <= `UDS_ZERO32;
      den     <= `UDS_ZERO32;
      rt      <= `UDS_ZERO16;
      root_op <= 1'b0;
    end
    else
    begin
      acc     <= next_acc;
      shf     <= next_shf;
      den     <= next_den;
      rt      <= next_rt;
      root_op <= next_root_op;
    end
  end

  assign quotient  = shf;
  assign remainder = acc[31:0];
  assign root      = rt;

endmodule

// ### verification/uds_cpu_model.sv
`timescale 1ns/1ps

module uds_cpu_model
(
  input  wire logic        clk_sys,
  output logic             wr_en,
  output logic [1:0]       wr_sel,
  output logic [3:0]       wr_be,
  output logic [31:0]      wr_data
);
  // bus idle at time zero
  initial
  begin
    wr_en   = 1'b0;
    wr_sel  = 2'h3;
    wr_be   = 4'h0;
    wr_data = 32'h0000_0000;
  end

  // one write, held through its taking edge; data inverted after so stale values never match
  task automatic put(input logic [1:0] sel, input logic [3:0] be, input logic [31:0] data);
    @(posedge clk_sys);
    wr_en   <= 1'b1;
    wr_sel  <= sel;
    wr_be   <= be;
    wr_data <= data;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
    wr_sel  <= ~sel;
    wr_data <= ~data;
  endtask
endmodule

// ### verification/test_unsigned_divider_square_root.sv
`timescale 1ns/1ps

module test_unsigned_divider_square_root;
  typedef struct packed
  {
    logic [1:0]  sel;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] q;
    logic [31:0] r;
    logic [15:0] rt;
    logic        z;
  } uds_row_t;

  logic        clk_sys;
  logic        arst_n;
  logic        irq_en;
  logic        wr_en;
  logic [1:0]  wr_sel;
  logic [3:0]  wr_be;
  logic [31:0] wr_data;
  logic [31:0] quotient;
  logic [31:0] remainder;
  logic [15:0] root;
  logic        busy;
  logic        done_flag;
  logic        zero_div_flag;
  logic        irq;
  int          n_fail;
  int          comparisons;

  // divisions name dividend and divisor; roots use a as radicand; z is the flag after the row
  localparam uds_row_t rows [0:10] = '{
    '{2'h1, 32'h0000_0064, 32'h0000_0007, 32'h0000_000E, 32'h0000_0002, 16'h0000, 1'b0},
    '{2'h1, 32'hFFFF_FFFF, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0000, 16'h0000, 1'b0},
    '{2'h1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 16'h0000, 1'b0},
    '{2'h1, 32'h8000_0000, 32'h0000_0003, 32'h2AAA_AAAA, 32'h0000_0002, 16'h0000, 1'b0},
    '{2'h1, 32'h0000_0064, 32'h8000_0000, 32'h0000_0000, 32'h0000_0064, 16'h0000, 1'b0},
    '{2'h1, 32'h0000_0005, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0005, 16'h0000, 1'b1},
    '{2'h2, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 16'h0000, 1'b1},
    '{2'h2, 32'h0000_000F, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 16'h0003, 1'b1},
    '{2'h2, 32'h0000_0010, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 16'h0004, 1'b1},
    '{2'h2, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 16'hFFFF, 1'b1},
    '{2'h2, 32'h8000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 16'hB504, 1'b1}
  };

  uds_top u_uds_top
  (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .wr_en         (wr_en),
    .wr_sel        (wr_sel),
    .wr_be         (wr_be),
    .wr_data       (wr_data),
    .irq_en        (irq_en),
    .quotient      (quotient),
    .remainder     (remainder),
    .root          (root),
    .busy          (busy),
    .done_flag     (done_flag),
    .zero_div_flag (zero_div_flag),
    .irq           (irq)
  );

  uds_cpu_model u_uds_cpu_model
  (
    .clk_sys (clk_sys),
    .wr_en   (wr_en),
    .wr_sel  (wr_sel),
    .wr_be   (wr_be),
    .wr_data (wr_data)
  );

  // 125 MHz
  always #4 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // counts edges from the taking edge until done shows; bounded so a hang ends the run
  task automatic wait_done(input int n);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k == 1)
        chk({30'h0, busy, done_flag}, 32'h0000_0002);
    end
    while (done_flag !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      finish_test();
    end
    else
    begin
      chk(32'(k), 32'(n));
      chk({31'h0, busy}, 32'h0000_0000);
    end
  endtask

  initial
  begin
    clk_sys     = 1'b0;
    arst_n      = 1'b0;
    irq_en      = 1'b0;
    n_fail      = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(quotient | remainder, 32'h0000_0000);
    chk({12'h000, root, busy, done_flag, zero_div_flag, irq}, 32'h0000_0000);
    // ordinary operations
    for (int i = 0; i < 11; i++)
    begin
      if (rows[i].sel == 2'h1)
        u_uds_cpu_model.put(2'h0, 4'hF, rows[i].a);
      u_uds_cpu_model.put(rows[i].sel, 4'hF, (rows[i].sel == 2'h1) ? rows[i].b : rows[i].a);
      wait_done(8);
      if (rows[i].sel == 2'h1)
      begin
        chk(quotient, rows[i].q);
        chk(remainder, rows[i].r);
      end
      else
        chk({16'h0000, root}, {16'h0000, rows[i].rt});
      chk({31'h0, zero_div_flag}, {31'h0, rows[i].z});
    end
    // partial-word and unused-select writes must start nothing
    u_uds_cpu_model.put(2'h2, 4'h3, 32'h0000_0009);
    u_uds_cpu_model.put(2'h3, 4'hF, 32'h0000_0009);
    @(posedge clk_sys);
    #1;
    chk({14'h0, busy, done_flag, root}, {16'h0001, 16'hB504});
    // a write arriving while busy is dropped; irq follows done by one edge
    u_uds_cpu_model.put(2'h0, 4'hF, 32'h0000_0064);
    u_uds_cpu_model.put(2'h1, 4'hF, 32'h0000_000A);
    irq_en <= 1'b1;
    u_uds_cpu_model.put(2'h2, 4'hF, 32'h0000_0031);
    wait_done(6);
    chk(quotient, 32'h0000_000A);
    // every accepted load clears the root, so the dropped radicand shows as zero
    chk({16'h0000, root}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge clk_sys);
    irq_en <= 1'b0;
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    // dividend is kept for a later divisor write
    u_uds_cpu_model.put(2'h1, 4'hF, 32'h0000_0003);
    wait_done(8);
    chk(remainder, 32'h0000_0001);
    // next start taken in the first cycle done shows
    u_uds_cpu_model.put(2'h2, 4'hF, 32'h0000_0019);
    repeat (7) @(posedge clk_sys);
    u_uds_cpu_model.put(2'h2, 4'hF, 32'h0000_0024);
    wait_done(8);
    chk({16'h0000, root}, 32'h0000_0006);
    // reset in mid-division clears everything at once; the unit works again after it
    u_uds_cpu_model.put(2'h1, 4'hF, 32'h0000_0007);
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(quotient | remainder, 32'h0000_0000);
    chk({12'h000, root, busy, done_flag, zero_div_flag, irq}, 32'h0000_0000);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    u_uds_cpu_model.put(2'h0, 4'hF, 32'h0000_0064);
    u_uds_cpu_model.put(2'h1, 4'hF, 32'h0000_0007);
    wait_done(8);
    chk(quotient, 32'h0000_000E);
    chk(remainder, 32'h0000_0002);
    finish_test();
  end
endmodule
